// file: design/gwk_top.sv
// gpio wake enable gate: wake enables, wake status, gated wake output
// assumes nrst is the standby-rail power-on reset; main_reset is a
// same-clock pulse for main-supply, soft and hard resets
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module gwk_top
   import gwk_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              main_reset,
   input  wire gwk_bus_req_t      bus_req,
   output var  logic [DATA_W-1:0] rd_data,
   input  wire gwk_src_t          general_pin,
   output var  logic              wake_event_out_n,
   output var  logic              irq
);
   localparam logic [GRP_N-1:0][ADDR_W-1:0] OFS_EN = {OFS_GRP3_EN, OFS_GRP1_EN};
   localparam logic [GRP_N-1:0][ADDR_W-1:0] OFS_ST = {OFS_GRP3_ST, OFS_GRP1_ST};

   gwk_src_t              pin_level;
   gwk_src_t              pin_rise;
   gwk_src_t              wake_en_reg;
   gwk_src_t              wake_st_reg;
   gwk_src_t              gated;
   logic                  global_event_enable;
   logic [IRQ_W-1:0]      irq_st_reg;
   logic [IRQ_W-1:0]      irq_mask_reg;
   logic [IRQ_W-1:0]      irq_ev;
   logic [DATA_W-1:0]     rd_data_reg;
   logic [DATA_W-1:0]     rd_data_next;
   logic                  wake_n_reg;
   logic                  wake_n_next;
   logic                  irq_reg;
   logic                  any_gated;

   gwk_sync #(
      .W (GRP_N*SRC_W)
   ) u_sync (
      .clk    (clk),
      .nrst   (nrst),
      .pin_in (general_pin),
      .level  (pin_level),
      .rise   (pin_rise)
   );

   genvar g;
   generate
      for (g = 0; g < GRP_N; g++) begin : g_grp
         // enables only see the standby reset, not main_reset
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               wake_en_reg[g] <= RST_WAKE_EN;
            end else if (bus_req.wr && bus_req.addr == OFS_EN[g]) begin
               wake_en_reg[g] <= bus_req.wdata;
            end
         end

         // status sets on any event regardless of enable; set beats clear
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               wake_st_reg[g] <= RST_WAKE_ST;
            end else if (bus_req.wr && bus_req.addr == OFS_ST[g]) begin
               wake_st_reg[g] <= (wake_st_reg[g] & ~bus_req.wdata) | pin_rise[g];
            end else begin
               wake_st_reg[g] <= wake_st_reg[g] | pin_rise[g];
            end
         end

         // bit n of the enable gates bit n of the status
         assign gated[g] = wake_en_reg[g] & wake_st_reg[g];
         assign irq_ev[g] = |pin_rise[g];
      end
   endgenerate

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         global_event_enable <= RST_GEE;
      end else if (bus_req.wr && bus_req.addr == OFS_CTRL) begin
         global_event_enable <= bus_req.wdata[CTRL_GEE_BIT];
      end
   end

   // output term: enable and status and global enable, ored over all
   assign any_gated = |gated;
   assign wake_n_next = ~(any_gated & global_event_enable);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wake_n_reg <= 1'b1;
      end else begin
         wake_n_reg <= wake_n_next;
      end
   end

   // interrupt: sticky per-group event bits, w1c, set wins
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_st_reg <= RST_IRQ;
      end else if (bus_req.wr && bus_req.addr == OFS_IRQ_ST) begin
         irq_st_reg <= (irq_st_reg & ~bus_req.wdata[IRQ_W-1:0]) | irq_ev;
      end else begin
         irq_st_reg <= irq_st_reg | irq_ev;
      end
   end

   // mask is the one piece of state that main_reset clears
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_mask_reg <= RST_IRQ;
      end else if (main_reset) begin
         irq_mask_reg <= RST_IRQ;
      end else if (bus_req.wr && bus_req.addr == OFS_IRQ_MASK) begin
         irq_mask_reg <= bus_req.wdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_st_reg & irq_mask_reg);
      end
   end

   always_comb begin
      rd_data_next = RST_RD_DATA;
      case (bus_req.addr)
         OFS_GRP1_EN:  rd_data_next = wake_en_reg[0];
         OFS_GRP3_EN:  rd_data_next = wake_en_reg[1];
         OFS_GRP1_ST:  rd_data_next = wake_st_reg[0];
         OFS_GRP3_ST:  rd_data_next = wake_st_reg[1];
         OFS_CTRL:     rd_data_next[CTRL_GEE_BIT] = global_event_enable;
         OFS_IRQ_ST:   rd_data_next[IRQ_W-1:0] = irq_st_reg;
         OFS_IRQ_MASK: rd_data_next[IRQ_W-1:0] = irq_mask_reg;
         default:      rd_data_next = RST_RD_DATA;
      endcase
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_data_reg <= RST_RD_DATA;
      end else if (bus_req.rd) begin
         rd_data_reg <= rd_data_next;
      end else begin
         rd_data_reg <= RST_RD_DATA;
      end
   end

   assign rd_data          = rd_data_reg;
   assign wake_event_out_n = wake_n_reg;
   assign irq              = irq_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_write_en3;
      bus_req.wr && bus_req.addr == OFS_GRP3_EN;
   endsequence

   sequence s_read_en3;
      bus_req.rd && bus_req.addr == OFS_GRP3_EN;
   endsequence

   property p_en3_write;
      s_write_en3 |=> wake_en_reg[1] == $past(bus_req.wdata);
   endproperty
   a_en3_write : assert property (p_en3_write)
      else $error("group3 enable write lost");

   property p_en3_readback;
      s_write_en3 ##1 s_read_en3 |=> rd_data == $past(bus_req.wdata, 2);
   endproperty
   a_en3_readback : assert property (p_en3_readback)
      else $error("group3 enable readback wrong");

   property p_bit_map;
      (pin_rise[1] != '0 && wake_en_reg[1] == 8'hff && global_event_enable && !bus_req.wr)
         |=> ##1 !wake_event_out_n;
   endproperty
   a_bit_map : assert property (p_bit_map)
      else $error("group3 pin did not reach wake output");

   property p_main_reset_keeps;
      (main_reset && !bus_req.wr) |=> $stable(wake_en_reg);
   endproperty
   a_main_reset_keeps : assert property (p_main_reset_keeps)
      else $error("main reset disturbed wake enables");

   property p_wake_assert;
      (any_gated && global_event_enable) |=> !wake_event_out_n;
   endproperty
   a_wake_assert : assert property (p_wake_assert)
      else $error("wake output missed gated term");

   property p_wake_needs_gee;
      !global_event_enable |=> wake_event_out_n;
   endproperty
   a_wake_needs_gee : assert property (p_wake_needs_gee)
      else $error("wake output without global enable");

   property p_disabled_records;
      ((pin_rise & ~wake_en_reg) != '0)
         |=> ((wake_st_reg & $past(pin_rise & ~wake_en_reg)) == $past(pin_rise & ~wake_en_reg));
   endproperty
   a_disabled_records : assert property (p_disabled_records)
      else $error("disabled source not recorded");

   property p_disabled_silent;
      (gated == '0) |=> wake_event_out_n;
   endproperty
   a_disabled_silent : assert property (p_disabled_silent)
      else $error("wake output with no gated term");

   property p_status_set;
      (pin_rise != '0) |=> ((wake_st_reg & $past(pin_rise)) == $past(pin_rise));
   endproperty
   a_status_set : assert property (p_status_set)
      else $error("wake event did not set status");

   property p_en1_write;
      (bus_req.wr && bus_req.addr == OFS_GRP1_EN) |=> wake_en_reg[0] == $past(bus_req.wdata);
   endproperty
   a_en1_write : assert property (p_en1_write)
      else $error("group1 enable write lost");

   property p_wake_hold;
      (!wake_event_out_n && any_gated && global_event_enable)[*2] |=> !wake_event_out_n;
   endproperty
   a_wake_hold : assert property (p_wake_hold)
      else $error("wake output dropped while term true");

   sequence s_clear_st3;
      bus_req.wr && bus_req.addr == OFS_GRP3_ST && pin_rise[1] == '0;
   endsequence

   property p_st3_clear;
      s_clear_st3 |=> wake_st_reg[1] == ($past(wake_st_reg[1]) & ~$past(bus_req.wdata));
   endproperty
   a_st3_clear : assert property (p_st3_clear)
      else $error("group3 status clear wrong");

   property p_en3_hold;
      !(bus_req.wr && bus_req.addr == OFS_GRP3_EN) |=> $stable(wake_en_reg[1]);
   endproperty
   a_en3_hold : assert property (p_en3_hold)
      else $error("group3 enable changed without write");

   property p_en1_hold;
      !(bus_req.wr && bus_req.addr == OFS_GRP1_EN) |=> $stable(wake_en_reg[0]);
   endproperty
   a_en1_hold : assert property (p_en1_hold)
      else $error("group1 enable changed without write");

   property p_gee_write;
      (bus_req.wr && bus_req.addr == OFS_CTRL)
         |=> global_event_enable == $past(bus_req.wdata[CTRL_GEE_BIT]);
   endproperty
   a_gee_write : assert property (p_gee_write)
      else $error("global enable write lost");

   property p_wake_needs_term;
      !wake_event_out_n |-> $past(any_gated && global_event_enable);
   endproperty
   a_wake_needs_term : assert property (p_wake_needs_term)
      else $error("wake output without gated term");

   property p_rise_from_low;
      (pin_rise != '0) |-> ((pin_level & pin_rise) == '0);
   endproperty
   a_rise_from_low : assert property (p_rise_from_low)
      else $error("wake event without settled low level");

   property p_irq_set;
      (irq_ev != '0) |=> ((irq_st_reg & $past(irq_ev)) == $past(irq_ev));
   endproperty
   a_irq_set : assert property (p_irq_set)
      else $error("group event did not set interrupt status");

   property p_irq_on;
      ((irq_st_reg & irq_mask_reg) != '0) |=> irq;
   endproperty
   a_irq_on : assert property (p_irq_on)
      else $error("interrupt missing for unmasked status");

   property p_irq_off;
      ((irq_st_reg & irq_mask_reg) == '0) |=> !irq;
   endproperty
   a_irq_off : assert property (p_irq_off)
      else $error("interrupt without unmasked status");

   property p_mask_main_reset;
      main_reset |=> irq_mask_reg == RST_IRQ;
   endproperty
   a_mask_main_reset : assert property (p_mask_main_reset)
      else $error("main reset kept interrupt mask");

   property p_rd_idle;
      !bus_req.rd |=> rd_data == RST_RD_DATA;
   endproperty
   a_rd_idle : assert property (p_rd_idle)
      else $error("read data outside read cycle");
endmodule
`default_nettype wire

// file: design/gwk_pkg.sv
// gpio wake enable gate: shared constants and carrier types
// assumes one 50 MHz clock and a plain byte-wide register port
package gwk_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int SRC_W  = 8;
   localparam int GRP_N  = 2;
   localparam int IRQ_W  = 2;

   localparam logic [ADDR_W-1:0] OFS_GRP1_EN   = 8'h0b;
   localparam logic [ADDR_W-1:0] OFS_GRP3_EN   = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_GRP1_ST   = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_GRP3_ST   = 8'h21;
   localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h22;
   localparam logic [ADDR_W-1:0] OFS_IRQ_ST    = 8'h23;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'h24;

   localparam logic [DATA_W-1:0] RST_WAKE_EN   = 8'h00;
   localparam logic [DATA_W-1:0] RST_WAKE_ST   = 8'h00;
   localparam logic [DATA_W-1:0] RST_RD_DATA   = 8'h00;
   localparam logic [IRQ_W-1:0]  RST_IRQ       = 2'h0;
   localparam logic              RST_GEE       = 1'b0;

   localparam int CTRL_GEE_BIT  = 0;
   localparam int IRQ_GRP1_BIT  = 0;
   localparam int IRQ_GRP3_BIT  = 1;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } gwk_bus_req_t;

   // index 0: pins 10..17, index 1: pins 30..37, bit n = pin x0+n
   typedef logic [GRP_N-1:0][SRC_W-1:0] gwk_src_t;
endpackage

// file: design/gwk_sync.sv
// gpio wake enable gate: pin input synchroniser with rise detect
// assumes asynchronous pins; a change counts once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module gwk_sync
   import gwk_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] pin_in,
   output var  logic [W-1:0] level,
   output var  logic [W-1:0] rise
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] lvl_reg;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               lvl_reg[i] <= 1'b0;
            end else if (s2_reg[i] == s3_reg[i]) begin
               lvl_reg[i] <= s3_reg[i];
            end
         end
         assign rise[i] = s2_reg[i] & s3_reg[i] & ~lvl_reg[i];
      end
   endgenerate

   assign level = lvl_reg;

   property p_rise_agreed;
      @(posedge clk) disable iff (!nrst)
         (rise != '0) |=> ((lvl_reg & $past(rise)) == $past(rise));
   endproperty
   a_rise_agreed : assert property (p_rise_agreed)
      else $error("rise did not settle level");
endmodule
`default_nettype wire

// file: test/gwk_host_model.sv
// host-side wake input model: counts wake assertions on the active-low line
// assumes the device drives the wake line from the same clock
`timescale 1ns/1ns
`default_nettype none
module gwk_host_model (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       wake_event_out_n,
   output var  logic [7:0] wake_cnt
);
   logic prev_n;
   // high-to-low edges only; a held level counts once
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prev_n   <= 1'b1;
         wake_cnt <= 8'h00;
      end else begin
         prev_n <= wake_event_out_n;
         if (prev_n && !wake_event_out_n) wake_cnt <= wake_cnt + 8'h01;
      end
   end
endmodule
`default_nettype wire

// file: test/tb.sv
// gpio wake gate testbench: enables, wake path, interrupt, reset kinds
// assumes gwk_pkg, gwk_top and gwk_host_model compiled before it
`timescale 1ns/1ns
`default_nettype none
module tb;
   import gwk_pkg::*;
   logic              clk = 1'b0;
   logic              nrst = 1'b0;
   logic              main_reset = 1'b0;
   gwk_bus_req_t      bus_req = '0;
   gwk_src_t          general_pin = '0;
   logic [DATA_W-1:0] rd_data;
   logic              wake_event_out_n;
   logic              irq;
   logic [7:0]        wake_cnt;
   int                n_mismatch = 0;
   int                total_checks = 0;
   always #10 clk = ~clk;
   gwk_top u_dut (.clk(clk), .nrst(nrst), .main_reset(main_reset), .bus_req(bus_req),
      .rd_data(rd_data), .general_pin(general_pin), .wake_event_out_n(wake_event_out_n),
      .irq(irq));
   gwk_host_model u_host (.clk(clk), .nrst(nrst), .wake_event_out_n(wake_event_out_n),
      .wake_cnt(wake_cnt));
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk) bus_req <= '{a, v, 1'b1, 1'b0};
      @(posedge clk) bus_req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk) bus_req.rd <= 1'b0;
      @(posedge clk) chk(rd_data, e);
   endtask
   // write then read back with no idle cycle between the strobes
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk) bus_req <= '{a, v, 1'b1, 1'b0};
      @(posedge clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk) bus_req <= '0;
      @(posedge clk) chk(rd_data, v);
   endtask
   task automatic chkw(input logic e);
      @(posedge clk) chk({7'h00, wake_event_out_n}, {7'h00, e});
   endtask
   task automatic chki(input logic e);
      @(posedge clk) chk({7'h00, irq}, {7'h00, e});
   endtask
   task automatic evt(input int g, input int k);
      @(posedge clk) general_pin[g][k] <= 1'b1;
      repeat (4) @(posedge clk);
      general_pin[g][k] <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic t_rw;
      rd(OFS_GRP3_EN, 8'h00);
      rd(OFS_GRP1_EN, 8'h00);
      chkw(1'b1);
      wr(OFS_GRP3_EN, 8'h55);
      wr(OFS_GRP1_EN, 8'ha3);
      wr(8'h0d, 8'hff);
      rd(OFS_GRP3_EN, 8'h55);
      rd(OFS_GRP1_EN, 8'ha3);
      rd(8'h0d, 8'h00);
      wr_rd(OFS_GRP3_EN, 8'h66);
      wr_rd(OFS_GRP1_EN, 8'h3c);
      $display("test rw done");
   endtask
   task automatic t_map;
      logic [7:0] m, ea, sa;
      wr(OFS_CTRL, 8'h01);
      for (int g = 0; g < 2; g++) begin
         ea = g ? OFS_GRP3_EN : OFS_GRP1_EN;
         sa = g ? OFS_GRP3_ST : OFS_GRP1_ST;
         wr(g ? OFS_GRP1_EN : OFS_GRP3_EN, 8'h00);
         for (int k = 0; k < 8; k++) begin
            m = 8'h01 << k;
            wr(ea, ~m);
            evt(g, k);
            rd(sa, m);
            chkw(1'b1);
            wr(ea, m);
            rd(ea, m);
            chkw(1'b0);
            wr(sa, m);
            rd(sa, 8'h00);
            chkw(1'b1);
         end
      end
      $display("test map done");
   endtask
   task automatic t_gee;
      wr(OFS_CTRL, 8'h00);
      wr(OFS_GRP3_EN, 8'hff);
      evt(1, 3);
      chkw(1'b1);
      wr(OFS_CTRL, 8'h01);
      rd(OFS_CTRL, 8'h01);
      chkw(1'b0);
      wr(OFS_GRP3_ST, 8'hff);
      rd(OFS_GRP3_ST, 8'h00);
      $display("test gee done");
   endtask
   task automatic t_or;
      logic [7:0] c;
      wr(OFS_GRP1_EN, 8'hff);
      evt(0, 7);
      evt(1, 0);
      chkw(1'b0);
      c = wake_cnt;
      wr(OFS_GRP1_ST, 8'h80);
      rd(OFS_GRP1_ST, 8'h00);
      chkw(1'b0);
      chk(wake_cnt, c);
      wr(OFS_GRP3_ST, 8'h01);
      rd(OFS_GRP3_ST, 8'h00);
      chkw(1'b1);
      $display("test or done");
   endtask
   task automatic t_irq;
      wr(OFS_IRQ_ST, 8'h03);
      rd(OFS_IRQ_ST, 8'h00);
      evt(1, 2);
      rd(OFS_IRQ_ST, 8'h02);
      chki(1'b0);
      wr(OFS_IRQ_MASK, 8'h02);
      rd(OFS_IRQ_MASK, 8'h02);
      chki(1'b1);
      wr(OFS_IRQ_ST, 8'h02);
      rd(OFS_IRQ_ST, 8'h00);
      chki(1'b0);
      wr(OFS_GRP3_ST, 8'h04);
      $display("test irq done");
   endtask
   task automatic t_keep;
      wr(OFS_GRP3_EN, 8'h5a);
      wr(OFS_GRP1_EN, 8'hc3);
      @(posedge clk) main_reset <= 1'b1;
      @(posedge clk) main_reset <= 1'b0;
      rd(OFS_GRP3_EN, 8'h5a);
      rd(OFS_GRP1_EN, 8'hc3);
      rd(OFS_IRQ_MASK, 8'h00);
      @(posedge clk) nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rd(OFS_GRP3_EN, 8'h00);
      rd(OFS_GRP1_EN, 8'h00);
      rd(OFS_CTRL, 8'h00);
      chkw(1'b1);
      $display("test keep done");
   endtask
   task automatic test_done;
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      t_rw;
      t_map;
      t_gee;
      t_or;
      t_irq;
      t_keep;
      test_done;
   end
   initial begin
      #200us;
      n_mismatch++;
      test_done;
   end
endmodule
`default_nettype wire
